// ### bench/capture_compare_array_properties.sv
// Purpose: port-level checks of the counter array
// Assumes: apb slave with one wait state
// Notes:   watchdog enable is mirrored from completed bus writes
`include "capture_compare_params.svh"
`timescale 1ns/10ps

module capture_compare_array_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  module_pin_oe_n,
    input wire logic        irq,
    input wire logic        watchdog_reset
);
    logic wdog_q; // copy of the watchdog enable bit

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // mirror only at the completing edge, as the slave does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr[9:2] == `IDX_MODE) begin
            wdog_q <= pwdata[`MOD_WDOG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    property p_one_wait;
        s_wait |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready missing after wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_err_zero;
        pslverr |-> prdata == 32'h00000000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("data on refused access");
    property p_idle_zero;
        !pready |-> prdata == 32'h00000000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data outside answer");
    property p_wdog_pulse;
        watchdog_reset |=> !watchdog_reset;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog pulse too long");
    property p_wdog_en;
        watchdog_reset |-> $past(wdog_q);
    endproperty
    a_wdog_en: assert property (p_wdog_en) else $error("watchdog fired disabled");
    property p_reset_out;
        $rose(presetn) |-> module_pin_oe_n == 5'h1F && !irq && !watchdog_reset;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset");
endmodule

// ### bench/pin_world.sv
// Purpose: outside world at the module pins
// Assumes: the array drives a pin while its oe_n is low
// Notes:   released pins show the far level, never a stale value
`timescale 1ns/10ps

module pin_world (
    input  wire logic [4:0] module_pin_out,
    input  wire logic [4:0] module_pin_oe_n,
    input  wire logic [4:0] far_level,
    output logic      [4:0] module_pin_in
);
    // resolved wire, pin n belongs to module n
    assign module_pin_in = (module_pin_oe_n & far_level) | (~module_pin_oe_n & module_pin_out);
endmodule

// ### bench/testbench.sv
// Purpose: self-checking bench of the counter array
// Assumes: one wait state apb answer
// Notes:   timer0 and external pulses give exact counts
`include "capture_compare_params.svh"
`timescale 1ns/10ps

module testbench;
    typedef struct packed {logic [7:0] i; logic [7:0] d; logic [7:0] e;} row_type;
    logic        pclk, presetn, psel, penable, pwrite, idle, timer0_overflow;
    logic        external_count_input, pready, pslverr, irq, watchdog_reset, er;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  module_pin_in, module_pin_out, module_pin_oe_n, far_level;
    logic [7:0]  rd;
    int          n_errors, comparisons, cycles, k;
    row_type     rows [8];

    capture_compare_array uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle(idle),
        .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
        .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
        .module_pin_oe_n(module_pin_oe_n), .irq(irq), .watchdog_reset(watchdog_reset));
    pin_world pins (.module_pin_out(module_pin_out), .module_pin_oe_n(module_pin_oe_n),
        .far_level(far_level), .module_pin_in(module_pin_in));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // hang guard, the run needs far fewer cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, request held until ready
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the hang guard ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk({24'h000000, rd}, {24'h000000, e});
    endtask
    task automatic tick();
        timer0_overflow <= 1'b1;
        @(posedge pclk);
        timer0_overflow <= 1'b0;
        @(posedge pclk);
    endtask
    // slower than a quarter of the clock
    task automatic fall();
        external_count_input <= 1'b1;
        repeat (4) @(posedge pclk);
        external_count_input <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, idle, timer0_overflow, external_count_input} = 7'h00;
        paddr = 10'h000;
        pwdata = 32'h00000000;
        far_level = 5'h00;
        // reserved bits always written as zero
        rows = '{'{8'hC1, 8'h87, 8'h87}, '{8'hC1, 8'h00, 8'h00}, '{8'hC6, 8'h30, 8'h30},
                 '{8'hD8, 8'hA5, 8'hA5}, '{8'hE0, 8'h5A, 8'h5A}, '{8'hD1, 8'h34, 8'h34},
                 '{8'hC0, 8'h9F, 8'h9F}, '{8'hC0, 8'h00, 8'h00}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdc(`IDX_CONTROL + i[7:0], 8'h00);
        chk(module_pin_oe_n, 5'h1F);
        apb(1'b0, 8'hFF, 8'h00);
        chk({er, rd}, 9'h100);
        fin("reset");
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].i, rows[i].d);
            rdc(rows[i].i, rows[i].e);
        end
        fin("rows");
        // exact counts from timer0 and external sources
        wr(8'hD0, 8'h00);
        wr(8'hC1, 8'h04);
        wr(8'hC0, 8'h40);
        repeat (5) tick();
        wr(8'hC0, 8'h00);
        rdc(8'hD0, 8'h05);
        wr(8'hC1, 8'h06);
        wr(8'hD0, 8'h00);
        wr(8'hC0, 8'h40);
        repeat (3) fall();
        wr(8'hC0, 8'h00);
        repeat (2) tick();
        rdc(8'hD0, 8'h03);
        // code 0: ten ticks in sixty edges of the free divider
        wr(8'hC1, 8'h00);
        wr(8'hD0, 8'h00);
        wr(8'hC0, 8'h40);
        repeat (56) @(posedge pclk);
        wr(8'hC0, 8'h00);
        rdc(8'hD0, 8'h0A);
        fin("sources");
        // rollover with internal source
        wr(8'hD0, 8'hFE);
        wr(8'hD1, 8'hFF);
        wr(8'hC1, 8'h03);
        wr(8'hC0, 8'h40);
        repeat (40) @(posedge pclk);
        rdc(8'hC0, 8'hC0);
        chk(irq, 1'b1);
        wr(8'hC1, 8'h02);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        rdc(8'hC0, 8'hC0);
        wr(8'hC0, 8'h00);
        rdc(8'hC0, 8'h00);
        fin("overflow");
        // idle gating
        wr(8'hD0, 8'h00);
        wr(8'hC1, 8'h84);
        idle <= 1'b1;
        wr(8'hC0, 8'h40);
        repeat (2) tick();
        rdc(8'hD0, 8'h00);
        idle <= 1'b0;
        repeat (2) tick();
        wr(8'hC0, 8'h00);
        rdc(8'hD0, 8'h02);
        fin("idle");
        // capture on selected edges only
        wr(8'hD0, 8'h34);
        wr(8'hD1, 8'h12);
        wr(8'hC2, 8'h20);
        far_level <= 5'h01;
        repeat (5) @(posedge pclk);
        rdc(8'hD8, 8'h34);
        rdc(8'hE0, 8'h12);
        rdc(8'hC0, 8'h01);
        wr(8'hD0, 8'h78);
        far_level <= 5'h00;
        repeat (5) @(posedge pclk);
        rdc(8'hD8, 8'h34);
        wr(8'hC2, 8'h10);
        far_level <= 5'h01;
        repeat (5) @(posedge pclk);
        far_level <= 5'h00;
        repeat (5) @(posedge pclk);
        rdc(8'hD8, 8'h78);
        wr(8'hC2, 8'h00);
        wr(8'hC0, 8'h00);
        fin("capture");
        // match with toggle, flag and interrupt on module 1
        wr(8'hD9, 8'h03);
        wr(8'hE1, 8'h00);
        wr(8'hD0, 8'h00);
        wr(8'hD1, 8'h00);
        wr(8'hC3, 8'h4D);
        wr(8'hC1, 8'h04);
        wr(8'hC0, 8'h40);
        repeat (3) tick();
        repeat (3) @(posedge pclk);
        chk(module_pin_out[1], 1'b1);
        chk(module_pin_oe_n[1], 1'b0);
        chk(irq, 1'b1);
        rdc(8'hC0, 8'h42);
        wr(8'hC3, 8'h0C);
        wr(8'hC0, 8'h40);
        wr(8'hD0, 8'h00);
        repeat (3) tick();
        repeat (3) @(posedge pclk);
        rdc(8'hC0, 8'h40);
        chk(module_pin_out[1], 1'b1);
        wr(8'hC0, 8'h00);
        wr(8'hC3, 8'h00);
        fin("match");
        // pwm level and glitch-free reload on module 2
        wr(8'hC4, 8'h42);
        wr(8'hDA, 8'h80);
        wr(8'hE2, 8'hC0);
        wr(8'hD0, 8'h10);
        repeat (3) @(posedge pclk);
        chk(module_pin_out[2], 1'b0);
        wr(8'hD0, 8'h90);
        repeat (3) @(posedge pclk);
        chk(module_pin_out[2], 1'b1);
        wr(8'hD0, 8'hFF);
        wr(8'hC0, 8'h40);
        tick();
        wr(8'hC0, 8'h00);
        rdc(8'hDA, 8'hC0);
        wr(8'hC4, 8'h00);
        fin("pwm");
        // watchdog match on module 4
        wr(8'hDC, 8'h02);
        wr(8'hE4, 8'h00);
        wr(8'hC6, 8'h40);
        wr(8'hD0, 8'h00);
        wr(8'hD1, 8'h00);
        wr(8'hC1, 8'h44);
        wr(8'hC0, 8'h40);
        repeat (2) tick();
        k = 0;
        while (watchdog_reset !== 1'b1 && k < 8) begin
            @(posedge pclk);
            k++;
        end
        chk(watchdog_reset, 1'b1);
        wr(8'hC0, 8'h00);
        fin("watchdog");
        // mid-run reset clears live state
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({irq, watchdog_reset, module_pin_oe_n}, 7'h1F);
        rdc(8'hC1, 8'h00);
        rdc(8'hC6, 8'h00);
        rdc(8'hDC, 8'h00);
        fin("reset again");
        conclude();
    end
endmodule

bind capture_compare_array capture_compare_array_properties chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_pin_oe_n(module_pin_oe_n), .irq(irq), .watchdog_reset(watchdog_reset));

// ### core/capture_compare_array.sv
// Purpose: shared 16-bit counter with five capture/compare modules
// Assumes: pclk is the oscillator; inputs synchronous to pclk
// Notes:   apb slave, one wait state on every access
//
// Functional notes
// - one shared 16-bit counter, five modules
// - mode bits 2:1 choose increment source
// - run bit 6 starts and stops counter
// - overflow sets flag bit 7, irq if enabled
// - software may set overflow flag; only software clears
// - module flags bits 0-4 set on events
// - all interrupts share one request line
// - module mode bit 0 enables module irq
// - module mode bit 1 selects pwm
// - bit 2 toggles pin on match
// - bit 3 sets flag on match
// - bits 4/5 capture falling/rising edges
// - bit 6 enables the comparator
// - each module has 16-bit value pair
// - mode bit 7 gates counter off in idle
// - mode bit 6 enables module 4 watchdog
// - mode bit 0 enables overflow interrupt
// - module n owns pin n
// - enabled edge copies counter into value pair
// - pwm pin low below compare, else high
// - pwm low byte reloads from high at wrap
// - watchdog match makes internal reset only
`include "capture_compare_params.svh"
`timescale 1ns/10ps

module capture_compare_array (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idle,
    input  wire logic        timer0_overflow,
    input  wire logic        external_count_input,
    input  wire logic [4:0]  module_pin_in,
    output logic      [4:0]  module_pin_out,
    output logic      [4:0]  module_pin_oe_n,
    output logic             irq,
    output logic             watchdog_reset
);

    ////////////////////////////////////////////////////////////////////
    // state
    // every register resets on presetn, to zero except module_pin_oe_n to ones; there is no soft reset
    // fields sit in own flops; reads repack them,
    // reserved bits forced to zero

    // counter control flags
    logic        ovf_flag_q;
    logic        run_q;
    logic [4:0]  event_flag_q;
    // counter mode fields
    logic        idle_off_q;
    logic        wdog_en_q;
    logic [1:0]  src_q;
    logic        ovf_irq_en_q;
    // shared counter
    capture_compare_pkg::count_type cnt_q;
    logic        step_q;         // counter moved last edge
    logic [2:0]  presc_q;        // oscillator divider
    // external count input sampling
    logic        eci_s1_q;
    logic        eci_s2_q;
    logic        eci_s3_q;
    // per-module storage, indexed by module
    capture_compare_pkg::byte_type mode_q [5];
    capture_compare_pkg::byte_type vlo_q  [5];
    capture_compare_pkg::byte_type vhi_q  [5];
    logic [4:0]  pin_s1_q;
    logic [4:0]  pin_s2_q;
    logic [4:0]  pin_s3_q;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    // index is the word address; lanes above 7:0 ignored
    // acc is the completing edge only: a write lands once
    // unmapped index answers pslverr and changes nothing

    wire  [7:0]  idx      = paddr[9:2];
    wire         acc      = psel & penable & pready;
    wire         wr       = acc & pwrite;
    wire  [7:0]  wbyte    = pwdata[7:0];
    wire         hit_con  = (idx == `IDX_CONTROL);
    wire         hit_mod  = (idx == `IDX_MODE);
    wire         hit_cl   = (idx == `IDX_CNT_LOW);
    wire         hit_ch   = (idx == `IDX_CNT_HIGH);
    wire  [4:0]  hit_mm;          // module mode hits
    wire  [4:0]  hit_vl;          // value low hits
    wire  [4:0]  hit_vh;          // value high hits
    wire         mapped   = hit_con | hit_mod | hit_cl | hit_ch
                          | (|hit_mm) | (|hit_vl) | (|hit_vh);

    ////////////////////////////////////////////////////////////////////
    // count source and gating
    // every source reduces to a one-cycle pclk tick
    // limitation: external pulses under one pclk period
    // may be missed by the sampling flops

    wire         osc_tick = (presc_q == `PRESCALE_LAST);
    // falling edge on the external count input
    wire         eci_fall = eci_s3_q & ~eci_s2_q;
    capture_compare_pkg::count_src_type src;
    assign src = capture_compare_pkg::count_src_type'(src_q);

    logic        src_tick;
    // pick the increment source
    always_comb begin
        case (src)
            capture_compare_pkg::src_osc_a:    src_tick = osc_tick;
            capture_compare_pkg::src_osc_b:    src_tick = osc_tick;
            capture_compare_pkg::src_timer0:   src_tick = timer0_overflow;
            capture_compare_pkg::src_external: src_tick = eci_fall;
            default:                           src_tick = 1'b0;
        endcase
    end

    // run bit and idle gate both hold the counter
    wire         cnt_on  = run_q & ~(idle & idle_off_q);
    wire         tick    = cnt_on & src_tick;
    wire         ovf     = tick & (cnt_q == 16'hFFFF);
    wire         lo_wrap = tick & (cnt_q[7:0] == 8'hFF);

    // software writes win over counting
    // a tick lost to a counter write is not made up
    wire  [15:0] cnt_d   = (wr & hit_cl) ? {cnt_q[15:8], wbyte}
                         : (wr & hit_ch) ? {wbyte, cnt_q[7:0]}
                         : tick          ? cnt_q + 16'h0001
                         : cnt_q;

    ////////////////////////////////////////////////////////////////////
    // per-module events
    // one generate copy per module: pin n, flag n
    // match waits for step_q, so a stopped counter on a
    // compare value does not re-fire every cycle; a
    // software counter write is no step, but one landing with a tick sets step_q and can match

    wire  [4:0]  match;           // comparator hit this edge
    wire  [4:0]  capture;         // enabled pin edge
    wire  [4:0]  event_set;       // sets module flag
    wire  [4:0]  irq_term;        // flag gated by enable
    wire  [7:0]  rd_term [5];     // read contribution

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_mod
            wire [7:0] m   = mode_q[i];
            wire       pwm = m[`MM_PWM];
            wire       rise = pin_s2_q[i] & ~pin_s3_q[i];
            wire       fall = pin_s3_q[i] & ~pin_s2_q[i];

            assign hit_mm[i] = (idx == (`IDX_MODULE0 + 8'(i)));
            assign hit_vl[i] = (idx == (`IDX_VAL_LOW0 + 8'(i)));
            assign hit_vh[i] = (idx == (`IDX_VAL_HIGH0 + 8'(i)));

            // compare only after the counter moved, one hit per value
            assign match[i] = m[`MM_CMP_EN] & step_q
                            & (cnt_q == {vhi_q[i], vlo_q[i]});
            assign capture[i] = (m[`MM_CAP_RISE] & rise)
                              | (m[`MM_CAP_FALL] & fall);
            assign event_set[i] = capture[i]
                                | (m[`MM_FLAG_MATCH] & match[i] & ~pwm);
            assign irq_term[i] = event_flag_q[i] & m[`MM_IRQ_EN];

            assign rd_term[i] = (hit_mm[i] ? (m & `MASK_MODULE) : 8'h00)
                              | (hit_vl[i] ? vlo_q[i] : 8'h00)
                              | (hit_vh[i] ? vhi_q[i] : 8'h00);

            // mode register
            // bit 7 is stored but reads back as zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode_q[i] <= `RST_BYTE;
                end else if (wr & hit_mm[i]) begin
                    mode_q[i] <= wbyte;
                end
            end

            // value pair: write, capture, or pwm reload
            // write beats capture, capture beats reload
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vlo_q[i] <= `RST_BYTE;
                    vhi_q[i] <= `RST_BYTE;
                end else begin
                    if (wr & hit_vl[i]) begin
                        vlo_q[i] <= wbyte;
                    end else if (capture[i]) begin
                        vlo_q[i] <= cnt_q[7:0];
                    end else if (pwm & lo_wrap) begin
                        vlo_q[i] <= vhi_q[i];
                    end
                    if (wr & hit_vh[i]) begin
                        vhi_q[i] <= wbyte;
                    end else if (capture[i]) begin
                        vhi_q[i] <= cnt_q[15:8];
                    end
                end
            end

            // pin drive; driven in pwm or toggle mode, else input
            // pwm wins, so a pwm pin never flips on a match
            // leaving both modes hands the pin back
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    module_pin_out[i]  <= 1'b0;
                    module_pin_oe_n[i] <= 1'b1;
                end else begin
                    module_pin_oe_n[i] <= ~(pwm | m[`MM_TOGGLE]);
                    if (pwm) begin
                        // low below the compare byte, high at or above
                        module_pin_out[i] <= (cnt_q[7:0] >= vlo_q[i]);
                    end else if (m[`MM_TOGGLE] & match[i]) begin
                        module_pin_out[i] <= ~module_pin_out[i];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read data mux
    // at most one hit is true, so the or is a select
    // registered into prdata during the wait cycle

    logic [7:0] rmux;
    // or together the hit registers; reserved bits read zero
    always_comb begin
        rmux = 8'h00;
        if (hit_con) begin
            rmux = {ovf_flag_q, run_q, 1'b0, event_flag_q};
        end
        if (hit_mod) begin
            rmux = {idle_off_q, wdog_en_q, 3'h0, src_q, ovf_irq_en_q};
        end
        if (hit_cl) begin
            rmux = cnt_q[7:0];
        end
        if (hit_ch) begin
            rmux = cnt_q[15:8];
        end
        for (int k = 0; k < 5; k++) begin
            rmux = rmux | rd_term[k];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb handshake: ready one cycle into the access phase
    // one wait state always, mapped or not
    // prdata is zero outside the answer, no stale bytes
    // trade-off: a fixed wait costs a cycle but keeps
    // the decode off a paddr to prdata path

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            // pulse ready once per access; drops after the taking edge
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= (psel & penable & ~pready & ~pwrite)
                     ? {24'h00_0000, rmux} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter control flags; hardware set beats software clear
    // a clear in the cycle of an event loses to it,
    // so software never loses a flag it has not seen
    // writing one sets a flag, handy to test the irq path

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q   <= 1'b0;
            run_q        <= 1'b0;
            event_flag_q <= 5'h00;
        end else begin
            if (wr & hit_con) begin
                run_q <= wbyte[`CON_RUN];
            end
            // software may write one too; only a write clears
            ovf_flag_q <= ((wr & hit_con) ? wbyte[`CON_OVF] : ovf_flag_q)
                        | ovf;
            event_flag_q <= ((wr & hit_con) ? wbyte[4:0] : event_flag_q)
                          | event_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter mode register; reserved bits are not stored
    // bits 5:3 are dropped on write, read back as zero
    // a new source acts from its next tick, no resync

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_off_q   <= 1'b0;
            wdog_en_q    <= 1'b0;
            src_q        <= 2'h0;
            ovf_irq_en_q <= 1'b0;
        end else if (wr & hit_mod) begin
            idle_off_q   <= wbyte[`MOD_IDLE_OFF];
            wdog_en_q    <= wbyte[`MOD_WDOG];
            src_q        <= wbyte[`MOD_SRC_HI:`MOD_SRC_LO];
            ovf_irq_en_q <= wbyte[`MOD_OVF_IRQ];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter, divider, input sampling
    // cnt_d already holds writes, ticks and hold,
    // so this block only registers it
    // the first sampling stage may be metastable;
    // nothing but the second stage reads it

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= 16'h0000;
            step_q   <= 1'b0;
            presc_q  <= 3'h0;
            eci_s1_q <= 1'b0;
            eci_s2_q <= 1'b0;
            eci_s3_q <= 1'b0;
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
        end else begin
            cnt_q    <= cnt_d;
            step_q   <= tick;
            // divider runs free so the rate is steady when started
            presc_q  <= osc_tick ? 3'h0 : presc_q + 3'h1;
            // two stages, third stage only for edge compare
            eci_s1_q <= external_count_input;
            eci_s2_q <= eci_s1_q;
            eci_s3_q <= eci_s2_q;
            pin_s1_q <= module_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt request and watchdog reset
    // irq is a level following flags and enables
    // watchdog_reset is a one-cycle internal pulse,
    // kept apart from presetn: no reset pin is driven

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq            <= 1'b0;
            watchdog_reset <= 1'b0;
        end else begin
            // one shared line for overflow and all modules
            irq <= (ovf_flag_q & ovf_irq_en_q) | (|irq_term);
            // internal pulse only; no reset pin is driven here
            watchdog_reset <= wdog_en_q & match[4];
        end
    end

endmodule

// ### core/capture_compare_params.svh
// Purpose: offsets, field positions, resets and counts of the counter array
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef CAPTURE_COMPARE_PARAMS_SVH
`define CAPTURE_COMPARE_PARAMS_SVH

// register indices
`define IDX_CONTROL     8'hC0
`define IDX_MODE        8'hC1
`define IDX_MODULE0     8'hC2
`define IDX_CNT_LOW     8'hD0
`define IDX_CNT_HIGH    8'hD1
`define IDX_VAL_LOW0    8'hD8
`define IDX_VAL_HIGH0   8'hE0

// counter control flags fields
`define CON_OVF         7
`define CON_RUN         6
// counter mode fields
`define MOD_IDLE_OFF    7
`define MOD_WDOG        6
`define MOD_SRC_HI      2
`define MOD_SRC_LO      1
`define MOD_OVF_IRQ     0
// module mode fields
`define MM_CMP_EN       6
`define MM_CAP_RISE     5
`define MM_CAP_FALL     4
`define MM_FLAG_MATCH   3
`define MM_TOGGLE       2
`define MM_PWM          1
`define MM_IRQ_EN       0

// reset values and masks
`define RST_BYTE        8'h00
`define MASK_CONTROL    8'hDF
`define MASK_MODE       8'hC7
`define MASK_MODULE     8'h7F

// oscillator divide for the internal count source
`define PRESCALE_DIV    6
`define PRESCALE_LAST   3'h5

`endif

// ### core/capture_compare_pkg.sv
// Purpose: shared types of the counter array
// Assumes: constants live in the params header
// Notes:   no constants here
package capture_compare_pkg;
    // increment source codes, in field order
    typedef enum logic [1:0] {
        src_osc_a,
        src_osc_b,
        src_timer0,
        src_external
    } count_src_type;

    typedef logic [7:0]  byte_type;
    typedef logic [15:0] count_type;
endpackage
